// ==== rtl/prs_pkg.sv ====
// constants and carrier types of the phase ring sequencer
// Notes on behaviour
// - sixteen phases, each owned by one of four rings
// - unlisted pairs conflict; concurrency groups form barriers
// - tables pick order; conflicting phases time together, later ring's green dropped
// - sixteen sequences, ordered list per each ring
// - eight slots per ring entry, zero unused
// - standard dual ring: 1-4 ring1, 5-8 ring2
// - eight phase sequential: no concurrency, order 1..8
// - quad sequential: ring1 1,2,3,4,7,8; ring2 5,6
// - user mode: more phases, rings; ring2 list may hold ring1 phases
// - ring mismatch between sequences: fault and flash
// - startup codes red, walk, green, yellow, red-clear, reserved
// - green startup clears pending pedestrian call
// - red-clear startup times start red before sequencing
// - other-ring partner must be in concurrent list
// - ungrouped phases time alone, others rest red
// - standard init loads sixteen lead/lag sequences
// - copy duplicates phase programming except ring assignment; phase zero ignored
// - beacon on auxiliary output, one phase, seconds
// - force-off extends green warning time, partner ends
// - beacon on except associated phase green with no ring in warning time
// - rings cross a barrier together
package prs_pkg;
  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_BEACON = 8'h02;
  localparam logic [7:0] ADDR_COPY = 8'h03;
  localparam logic [7:0] ADDR_RING = 8'h10;
  localparam logic [7:0] ADDR_START = 8'h20;
  localparam logic [7:0] ADDR_CONC = 8'h30;
  localparam logic [7:0] ADDR_TIME = 8'h40;
  localparam logic [7:0] ADDR_SEQ = 8'h80;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_INIT = 1;
  localparam int CTRL_FORCE = 2;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_SEQ_LO = 8;
  // ***************************************************************
  // modes and startup codes
  // ***************************************************************
  localparam logic [1:0] MODE_STD = 2'h0;
  localparam logic [1:0] MODE_SEQ8 = 2'h1;
  localparam logic [1:0] MODE_QUAD = 2'h2;
  localparam logic [1:0] MODE_USER = 2'h3;
  localparam logic [2:0] SU_RED = 3'h0;
  localparam logic [2:0] SU_WALK = 3'h1;
  localparam logic [2:0] SU_GREEN = 3'h2;
  localparam logic [2:0] SU_YELLOW = 3'h3;
  localparam logic [2:0] SU_RED_CLEARANCE_STARTUP = 3'h4;
  localparam int NPH = 16;
  localparam int NRING = 4;
  localparam int NSLOT = 8;
  localparam int NSEQ = 16;
  localparam int CLK_HZ = 125000000;
  localparam int START_RED_S = 2;
  localparam int YELLOW_S = 3;
  localparam logic [3:0] STD_RING2_BASE = 4'h5;
  typedef enum logic [4:0] {
    PRS_IDLE = 5'h01, PRS_GREEN = 5'h02, PRS_WARN = 5'h04,
    PRS_CLEAR = 5'h08, PRS_WAIT = 5'h10
  } prs_ring_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } prs_bus_s;
endpackage

// ==== rtl/prs_ring.sv ====
// one ring of the sequencer: slot walk and interval timing
`timescale 1ns/100ps
module prs_ring (
  input wire logic clock,
  input wire logic rstN,
  input wire logic tick,
  input wire logic run,
  input wire logic [31:0] slots,
  input wire logic forceOff,
  input wire logic [7:0] warnSec,
  input wire logic [3:0] warnPhase,
  input wire logic crossOk,
  output logic [3:0] phase,
  output logic green,
  output logic warn,
  output logic atBarrier
);
  typedef struct packed {
    prs_pkg::prs_ring_e st;
    logic [2:0] slot;
    logic [7:0] cnt;
  } prs_rs_s;
  prs_rs_s s_r, s_nxt;
  logic [3:0] cur;
  logic [2:0] nxtSlot;
  always_comb begin
    cur = slots[{s_r.slot, 2'b00} +: 4];
    nxtSlot = s_r.slot + 3'h1;
    if (slots[{nxtSlot, 2'b00} +: 4] == 4'h0) begin
      nxtSlot = 3'h0;
    end
  end
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      prs_pkg::PRS_IDLE: begin
        if (run && cur != 4'h0) begin
          s_nxt.st = prs_pkg::PRS_GREEN;
        end
      end
      prs_pkg::PRS_GREEN: begin
        if (forceOff) begin
          if (cur == warnPhase && warnSec != 8'h00) begin
            s_nxt.st = prs_pkg::PRS_WARN;
            s_nxt.cnt = warnSec;
          end else begin
            s_nxt.st = prs_pkg::PRS_CLEAR;
            s_nxt.cnt = 8'(prs_pkg::YELLOW_S);
          end
        end
      end
      prs_pkg::PRS_WARN: begin
        if (tick) begin
          s_nxt.cnt = s_r.cnt - 8'h01;
          if (s_r.cnt == 8'h01) begin
            s_nxt.st = prs_pkg::PRS_CLEAR;
            s_nxt.cnt = 8'(prs_pkg::YELLOW_S);
          end
        end
      end
      prs_pkg::PRS_CLEAR: begin
        if (tick) begin
          s_nxt.cnt = s_r.cnt - 8'h01;
          if (s_r.cnt <= 8'h01) begin
            s_nxt.st = prs_pkg::PRS_WAIT;
          end
        end
      end
      prs_pkg::PRS_WAIT: begin
        if (crossOk) begin
          s_nxt.slot = nxtSlot;
          s_nxt.st = run ? prs_pkg::PRS_GREEN : prs_pkg::PRS_IDLE;
        end
      end
      default: s_nxt.st = prs_pkg::PRS_IDLE;
    endcase
  end
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      s_r <= '{prs_pkg::PRS_IDLE, 3'h0, 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign phase = cur;
  assign green = (s_r.st == prs_pkg::PRS_GREEN) ||
                 (s_r.st == prs_pkg::PRS_WARN);
  assign warn = (s_r.st == prs_pkg::PRS_WARN);
  assign atBarrier = (s_r.st == prs_pkg::PRS_WAIT) || (cur == 4'h0);
  property p_warn_len;
    @(posedge clock) disable iff (!rstN)
      warn && !tick |=> warn;
  endproperty
  a_warn_len: assert property (p_warn_len)
    else $error("warn cut short");
  // warning time always hands over to clearance, never to wait
  sequence s_warn_drop;
    warn ##1 !warn;
  endsequence
  property p_warn_clear;
    @(posedge clock) disable iff (!rstN)
      s_warn_drop |-> s_r.st == prs_pkg::PRS_CLEAR;
  endproperty
  a_warn_clear: assert property (p_warn_clear)
    else $error("warn not followed by clearance");
endmodule // prs_ring

// ==== rtl/prs_top.sv ====
// phase ring sequencer top: registers, tables, rings, beacon
`timescale 1ns/100ps
module prs_top #(
  parameter int TICK_CYCLES = prs_pkg::CLK_HZ
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] pedCall,
  output logic [15:0] rdata,
  output logic [15:0] phaseGreen,
  output logic [15:0] pedClear,
  output logic flashOut,
  output logic beaconOut
);
  // ***************************************************************
  // reset release
  // ***************************************************************
  logic rs1_r, rstN;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rs1_r <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rstN <= rs1_r;
    end
  end
  // ***************************************************************
  // state
  // ***************************************************************
  localparam int NRG = prs_pkg::NRING;
  logic [31:0] seqTab_r [prs_pkg::NSEQ*prs_pkg::NRING];
  logic [1:0] ring_r [prs_pkg::NPH];
  logic [2:0] start_r [prs_pkg::NPH];
  logic [15:0] conc_r [prs_pkg::NPH];
  logic [15:0] time_r [prs_pkg::NPH];
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] beacon;
    logic [15:0] rdata;
    logic [15:0] green;
    logic [15:0] pedClr;
    logic fault;
    logic beacon_o;
    logic [31:0] tick;
    logic [7:0] startRed;
    logic [3:0] activeSeq;
  } prs_st_s;
  prs_st_s s_r, s_nxt;
  logic tick;
  logic [3:0] mode;
  logic [3:0] ringPh [NRG];
  logic [NRG-1:0] ringGrn, ringWarn, ringBar;
  logic [31:0] ringSlots [NRG];
  logic crossOk, ringBad, runOk;
  logic [3:0] reqSeq;
  assign mode = {2'b00, s_r.ctrl[prs_pkg::CTRL_MODE_LO +: 2]};
  assign reqSeq = s_r.ctrl[prs_pkg::CTRL_SEQ_LO +: 4];
  assign tick = (s_r.tick == 32'(TICK_CYCLES - 1));
  // ***************************************************************
  // ring consistency over all sequences
  // ***************************************************************
  always_comb begin
    ringBad = 1'b0;
    for (int q = 0; q < prs_pkg::NSEQ; q++) begin
      for (int r = 0; r < NRG; r++) begin
        for (int k = 0; k < prs_pkg::NSLOT; k++) begin
          // phase numbers are one-based, the ring table zero-based
          if (seqTab_r[q*NRG+r][k*4 +: 4] != 4'h0 && mode[1:0] ==
              prs_pkg::MODE_USER && ring_r[seqTab_r[q*NRG+r][k*4 +: 4]
              - 4'h1] != 2'(r) && !(r == 1 &&
              ring_r[seqTab_r[q*NRG+r][k*4 +: 4] - 4'h1] == 2'h0)) begin
            ringBad = 1'b1;
          end
        end
      end
    end
  end
  // ***************************************************************
  // slot lists per mode
  // ***************************************************************
  always_comb begin
    for (int r = 0; r < NRG; r++) begin
      ringSlots[r] = seqTab_r[s_r.activeSeq*NRG + r];
    end
    case (mode[1:0])
      prs_pkg::MODE_SEQ8: begin
        ringSlots[0] = 32'h87654321;
        ringSlots[1] = 32'h0;
        ringSlots[2] = 32'h0;
        ringSlots[3] = 32'h0;
      end
      prs_pkg::MODE_QUAD: begin
        ringSlots[0] = 32'h00874321;
        ringSlots[1] = 32'h00000065;
        ringSlots[2] = 32'h0;
        ringSlots[3] = 32'h0;
      end
      default: begin
      end
    endcase
  end
  // barrier: rings cross together
  assign crossOk = &ringBar;
  assign runOk = s_r.ctrl[prs_pkg::CTRL_RUN] && !s_r.fault &&
                 s_r.startRed == 8'h00;
  for (genvar g = 0; g < NRG; g++) begin : g_ring
    prs_ring u_ring (
      .clock(clock),
      .rstN(rstN),
      .tick(tick),
      .run(runOk),
      .slots(ringSlots[g]),
      .forceOff(s_r.ctrl[prs_pkg::CTRL_FORCE]),
      .warnSec(s_r.beacon[7:0]),
      .warnPhase(s_r.beacon[11:8]),
      .crossOk(crossOk),
      .phase(ringPh[g]),
      .green(ringGrn[g]),
      .warn(ringWarn[g]),
      .atBarrier(ringBar[g])
    );
  end
  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = tick ? 32'h0 : s_r.tick + 32'h1;
    s_nxt.rdata = 16'h0;
    s_nxt.green = 16'h0;
    for (int r = 0; r < NRG; r++) begin
      if (ringGrn[r] && ringPh[r] != 4'h0) begin
        s_nxt.green[ringPh[r]-4'h1] = 1'b1;
      end
    end
    // drop greens that conflict with an earlier ring
    for (int a = 0; a < NRG; a++) begin
      for (int b = 0; b < a; b++) begin
        if (ringGrn[a] && ringGrn[b] && ringPh[a] != 4'h0 &&
            ringPh[b] != 4'h0 && !conc_r[ringPh[a]-4'h1]
            [ringPh[b]-4'h1]) begin
          s_nxt.green[ringPh[a]-4'h1] = 1'b0;
        end
      end
    end
    if (ringBad) begin
      s_nxt.fault = 1'b1;
    end
    if (tick && s_r.startRed != 8'h00) begin
      s_nxt.startRed = s_r.startRed - 8'h01;
    end
    s_nxt.pedClr = 16'h0;
    for (int p = 0; p < prs_pkg::NPH; p++) begin
      if (start_r[p] == prs_pkg::SU_GREEN && pedCall[p] &&
          !s_r.ctrl[prs_pkg::CTRL_RUN]) begin
        s_nxt.pedClr[p] = 1'b1;
      end
    end
    s_nxt.beacon_o = 1'b1;
    if (s_r.beacon[11:8] != 4'h0 && s_nxt.green[s_r.beacon[11:8]-4'h1]
        && !(|ringWarn)) begin
      s_nxt.beacon_o = 1'b0;
    end
    if (rd) begin
      if (addr == prs_pkg::ADDR_CTRL) begin
        s_nxt.rdata = s_r.ctrl;
      end else if (addr == prs_pkg::ADDR_STATUS) begin
        s_nxt.rdata = {s_r.activeSeq, 10'h0, s_r.beacon_o, s_r.fault};
      end else if (addr == prs_pkg::ADDR_BEACON) begin
        s_nxt.rdata = s_r.beacon;
      end else if (addr[7:4] == prs_pkg::ADDR_RING[7:4]) begin
        s_nxt.rdata = {14'h0, ring_r[addr[3:0]]};
      end else if (addr[7:4] == prs_pkg::ADDR_START[7:4]) begin
        s_nxt.rdata = {13'h0, start_r[addr[3:0]]};
      end else if (addr[7:4] == prs_pkg::ADDR_CONC[7:4]) begin
        s_nxt.rdata = conc_r[addr[3:0]];
      end else if (addr[7:4] == prs_pkg::ADDR_TIME[7:4]) begin
        s_nxt.rdata = time_r[addr[3:0]];
      end else if (addr[7]) begin
        s_nxt.rdata = addr[0] ? seqTab_r[addr[6:1]][31:16]
                              : seqTab_r[addr[6:1]][15:0];
      end else begin
        s_nxt.rdata = 16'h0;
      end
    end
    if (wr) begin
      if (addr == prs_pkg::ADDR_CTRL) begin
        s_nxt.ctrl = wdata;
        s_nxt.ctrl[prs_pkg::CTRL_INIT] = 1'b0;
        if (wdata[prs_pkg::CTRL_RUN] && !s_r.ctrl[prs_pkg::CTRL_RUN]) begin
          s_nxt.startRed = 8'(prs_pkg::START_RED_S);
        end
        if (!ringBad) begin
          s_nxt.activeSeq = wdata[prs_pkg::CTRL_SEQ_LO +: 4];
        end
      end else if (addr == prs_pkg::ADDR_STATUS && wdata[0]) begin
        s_nxt.fault = ringBad;
      end else if (addr == prs_pkg::ADDR_BEACON) begin
        s_nxt.beacon = wdata;
      end
    end
  end
  // ***************************************************************
  // tables
  // ***************************************************************
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      for (int p = 0; p < prs_pkg::NPH; p++) begin
        ring_r[p] <= 2'(p / 4 > 1 ? p / 4 : p / 4);
        start_r[p] <= prs_pkg::SU_RED;
        conc_r[p] <= 16'h0;
        time_r[p] <= 16'h0;
      end
      for (int i = 0; i < prs_pkg::NSEQ*NRG; i++) begin
        seqTab_r[i] <= 32'h0;
      end
    end else begin
      if (wr && addr == prs_pkg::ADDR_CTRL && wdata[prs_pkg::CTRL_INIT]) begin
        for (int q = 0; q < prs_pkg::NSEQ; q++) begin
          seqTab_r[q*NRG] <= {16'h0, q[3] ? 4'h3 : 4'h4, q[3] ? 4'h4 : 4'h3,
                              q[1] ? 4'h1 : 4'h2, q[1] ? 4'h2 : 4'h1};
          seqTab_r[q*NRG+1] <= {16'h0, q[2] ? 4'h7 : 4'h8, q[2] ? 4'h8 : 4'h7,
                                q[0] ? 4'h5 : 4'h6, q[0] ? 4'h6 : 4'h5};
          seqTab_r[q*NRG+2] <= 32'h0;
          seqTab_r[q*NRG+3] <= 32'h0;
        end
        for (int p = 0; p < prs_pkg::NPH; p++) begin
          ring_r[p] <= (p < 4) ? 2'h0 : (p < 8) ? 2'h1 : 2'h2;
          conc_r[p] <= (p < 2 || (p > 3 && p < 6)) ? 16'h0033 : 16'h00CC;
        end
      end else if (wr && addr[7]) begin
        if (addr[0]) begin
          seqTab_r[addr[6:1]][31:16] <= wdata;
        end else begin
          seqTab_r[addr[6:1]][15:0] <= wdata;
        end
      end else if (wr && addr[7:4] == prs_pkg::ADDR_RING[7:4]) begin
        ring_r[addr[3:0]] <= wdata[1:0];
      end else if (wr && addr[7:4] == prs_pkg::ADDR_START[7:4]) begin
        start_r[addr[3:0]] <= wdata[2:0];
      end else if (wr && addr[7:4] == prs_pkg::ADDR_CONC[7:4]) begin
        conc_r[addr[3:0]] <= wdata;
      end else if (wr && addr[7:4] == prs_pkg::ADDR_TIME[7:4]) begin
        time_r[addr[3:0]] <= wdata;
      end else if (wr && addr == prs_pkg::ADDR_COPY && wdata[7:4] != 4'h0
                   && wdata[3:0] != 4'h0) begin
        time_r[wdata[3:0]-4'h1] <= time_r[wdata[7:4]-4'h1];
        start_r[wdata[3:0]-4'h1] <= start_r[wdata[7:4]-4'h1];
        conc_r[wdata[3:0]-4'h1] <= conc_r[wdata[7:4]-4'h1];
      end
    end
  end
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign rdata = s_r.rdata;
  assign phaseGreen = s_r.green;
  assign pedClear = s_r.pedClr;
  assign flashOut = s_r.fault;
  assign beaconOut = s_r.beacon_o;
  property p_flash;
    @(posedge clock) disable iff (!rstN) ringBad |=> flashOut;
  endproperty
  a_flash: assert property (p_flash) else $error("no flash");
  // only a status write may take the intersection out of flash
  property p_flash_hold;
    @(posedge clock) disable iff (!rstN)
      flashOut && !(wr && addr == prs_pkg::ADDR_STATUS) |=> flashOut;
  endproperty
  a_flash_hold: assert property (p_flash_hold)
    else $error("flash dropped");
  property p_seq8_one;
    @(posedge clock) disable iff (!rstN)
      mode[1:0] == prs_pkg::MODE_SEQ8 |=> $onehot0(phaseGreen);
  endproperty
  a_seq8_one: assert property (p_seq8_one)
    else $error("two greens in sequential mode");
  property p_beacon_dark;
    @(posedge clock) disable iff (!rstN)
      !beaconOut && $past(rstN) |-> (|phaseGreen);
  endproperty
  a_beacon_dark: assert property (p_beacon_dark)
    else $error("beacon dark without green");
endmodule // prs_top

// ==== tb/prs_cabinet.sv ====
// cabinet model: load switch watch and pedestrian detectors
`timescale 1ns/100ps
module prs_cabinet (
  input wire logic clock,
  input wire logic [15:0] phaseGreen,
  input wire logic beaconOut,
  input wire logic [3:0] assocPhase,
  input wire logic seqOnly,
  output logic [15:0] pedCall
);
  // ***************************************************************
  // detectors and switch watch
  // ***************************************************************
  logic [15:0] lastGreen;
  int onsetQ[$];
  int faults;
  int dark;
  initial begin
    lastGreen = 16'h0000;
    faults = 0;
    dark = 0;
    pedCall = 16'h0000;
  end
  // random buttons keep pedestrian logic busy during every test
  always @(posedge clock) begin
    pedCall <= 16'($urandom);
    lastGreen <= phaseGreen;
    for (int i = 0; i < 16; i++) begin
      if (phaseGreen[i] && !lastGreen[i]) begin
        onsetQ.push_back(i + 1);
      end
    end
    if (seqOnly && $countones(phaseGreen) > 1) begin
      faults++;
    end
    if (assocPhase != 4'h0) begin
      if (!phaseGreen[assocPhase - 1] && beaconOut !== 1'b1) begin
        faults++;
      end
      if (phaseGreen[assocPhase - 1] && beaconOut === 1'b0) begin
        dark++;
      end
    end
  end
endmodule // prs_cabinet

// ==== tb/testbench.sv ====
// self-checking bench of the phase ring sequencer
`timescale 1ns/100ps
module testbench;
  // ***************************************************************
  // clock, reset and register port
  // ***************************************************************
  localparam int TICK = 4;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] pedCall;
  logic [15:0] rdata;
  logic [15:0] phaseGreen;
  logic [15:0] pedClear;
  logic flashOut;
  logic beaconOut;
  logic [3:0] assoc = 4'h0;
  logic seqOnly = 1'b0;
  logic [15:0] v;
  logic [15:0] rv;
  int nErrors = 0;
  int cmpCount = 0;
  int expQ[$];
  always #4 clock = ~clock;
  prs_top #(.TICK_CYCLES(TICK)) prs_top_inst (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .pedCall(pedCall), .rdata(rdata),
    .phaseGreen(phaseGreen), .pedClear(pedClear),
    .flashOut(flashOut), .beaconOut(beaconOut)
  );
  prs_cabinet prs_cabinet_inst (
    .clock(clock), .phaseGreen(phaseGreen), .beaconOut(beaconOut),
    .assocPhase(assoc), .seqOnly(seqOnly), .pedCall(pedCall)
  );
  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // lead/lag defaults: seq bits swap pairs 1-2, 5-6, 3-4, 7-8
  function automatic logic [31:0] defSeq(int s, int r);
    logic [31:0] e;
    e = 32'h0;
    if (r == 0) begin
      e[7:0] = s[1] ? 8'h12 : 8'h21;
      e[15:8] = s[3] ? 8'h34 : 8'h43;
    end else if (r == 1) begin
      e[7:0] = s[0] ? 8'h56 : 8'h65;
      e[15:8] = s[2] ? 8'h78 : 8'h87;
    end
    return e;
  endfunction
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    int n;
    void'($urandom(32'h428913a0));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rdReg(prs_pkg::ADDR_CTRL, v);
    chk(v, 16'h0000);
    wrReg(8'h04, 16'hFFFF);
    rdReg(8'h04, v);
    chk(v, 16'h0000);
    $display("test reset and unmapped done");
    wrReg(prs_pkg::ADDR_CTRL, 16'h0002);
    wrReg(prs_pkg::ADDR_CTRL, 16'h0000);
    repeat (8) @(posedge clock);
    for (int s = 0; s < 16; s++) begin
      for (int r = 0; r < 4; r++) begin
        n = 2 * (s * 4 + r);
        rdReg(8'(prs_pkg::ADDR_SEQ + n), v);
        chk(v, defSeq(s, r)[15:0]);
        rdReg(8'(prs_pkg::ADDR_SEQ + n + 1), v);
        chk(v, defSeq(s, r)[31:16]);
      end
    end
    $display("test default sequences done");
    rv = 16'($urandom);
    wrReg(8'(prs_pkg::ADDR_CONC + 10), rv);
    wrReg(8'(prs_pkg::ADDR_START + 10), 16'(prs_pkg::SU_YELLOW));
    wrReg(8'(prs_pkg::ADDR_CONC + 13), ~rv);
    wrReg(prs_pkg::ADDR_COPY, 16'h00BD);
    wrReg(prs_pkg::ADDR_COPY, 16'h000E);
    repeat (4) @(posedge clock);
    rdReg(8'(prs_pkg::ADDR_CONC + 12), v);
    chk(v, rv);
    rdReg(8'(prs_pkg::ADDR_START + 12), v);
    chk(v, 16'(prs_pkg::SU_YELLOW));
    rdReg(8'(prs_pkg::ADDR_CONC + 13), v);
    chk(v, ~rv);
    $display("test copy done");
    wrReg(prs_pkg::ADDR_START, 16'(prs_pkg::SU_GREEN));
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      #1 n = int'(pedCall[0]);
      @(posedge clock);
      #1 chk(16'(pedClear[0]), 16'(n));
    end
    $display("test startup pedestrian clear done");
    for (int p = 0; p < 8; p++) begin
      wrReg(8'(prs_pkg::ADDR_TIME + p), 16'h0001);
      expQ.push_back(p + 1);
    end
    wrReg(prs_pkg::ADDR_BEACON, 16'h0201);
    repeat (4) @(posedge clock);
    assoc <= 4'h2;
    seqOnly <= 1'b1;
    prs_cabinet_inst.onsetQ.delete();
    wrReg(prs_pkg::ADDR_CTRL, 16'h0015);
    n = 0;
    while (prs_cabinet_inst.onsetQ.size() < 8 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 20000) begin
      nErrors++;
      close_out();
    end
    for (int i = 0; i < 8; i++) begin
      chk(16'(prs_cabinet_inst.onsetQ[i]), 16'(expQ[i]));
    end
    chk(16'(prs_cabinet_inst.faults), 16'h0000);
    chk(16'(prs_cabinet_inst.dark > 0), 16'h0001);
    $display("test sequential run and beacon done");
    seqOnly <= 1'b0;
    assoc <= 4'h0;
    wrReg(prs_pkg::ADDR_CTRL, 16'h0030);
    wrReg(8'(prs_pkg::ADDR_SEQ + 8), 16'h5321);
    repeat (4) @(posedge clock);
    rdReg(prs_pkg::ADDR_STATUS, v);
    chk(v & 16'h0001, 16'h0001);
    chk(16'(flashOut), 16'h0001);
    $display("test ring fault done");
    close_out();
  end
endmodule // testbench
